/* hw/wide_timer_params.svh */
/*
 Register addresses, field positions, reset values and timing counts of the
 byte-accessed wide timer. Assumes inclusion by bare name.
*/
`ifndef WIDE_TIMER_PARAMS_SVH
`define WIDE_TIMER_PARAMS_SVH

`define WT_ADDR_CNT_L 4'h0
`define WT_ADDR_CNT_H 4'h1
`define WT_ADDR_CMPA_L 4'h2
`define WT_ADDR_CMPA_H 4'h3
`define WT_ADDR_CMPB_L 4'h4
`define WT_ADDR_CMPB_H 4'h5
`define WT_ADDR_CAP_L 4'h6
`define WT_ADDR_CAP_H 4'h7
`define WT_ADDR_CTRL_A 4'h8
`define WT_ADDR_CTRL_B 4'h9
`define WT_ADDR_FLAG 4'ha
`define WT_ADDR_MASK 4'hb

`define WT_FLAG_OVF 0
`define WT_FLAG_CMPA 1
`define WT_FLAG_CMPB 2
`define WT_FLAG_CAP 3

`define WT_CTRLB_EDGE 6
`define WT_CTRLB_FILT 7
`define WT_CTRLB_SRC 5

`define WT_RESET_BYTE 8'h00
`define WT_RESET_WIDE 16'h0000
`define WT_BOTTOM 16'h0000
`define WT_MAX 16'hffff
`define WT_TOP_8BIT 16'h00ff
`define WT_TOP_9BIT 16'h01ff
`define WT_TOP_10BIT 16'h03ff

`define WT_PRESCALE_BITS 10
`define WT_FILTER_LEN 4

`endif

/* hw/wide_timer_pkg.sv */
/*
 Types for the byte-accessed wide timer.
 Assumes the params header is compiled alongside.
*/
package wide_timer_pkg;

   typedef logic [15:0] wide_t;

   typedef enum logic [3:0] {
      MODE_NORMAL = 4'h0,
      MODE_CTC_CMPA = 4'h4,
      MODE_PWM_8BIT = 4'h5,
      MODE_PWM_9BIT = 4'h6,
      MODE_PWM_10BIT = 4'h7,
      MODE_CTC_CAP = 4'hc,
      MODE_PWM_CAP = 4'he,
      MODE_PWM_CMPA = 4'hf
   } wave_mode_t;

   typedef enum logic [2:0] {
      CLK_STOP = 3'h0,
      CLK_DIV1 = 3'h1,
      CLK_DIV8 = 3'h2,
      CLK_DIV64 = 3'h3,
      CLK_DIV256 = 3'h4,
      CLK_DIV1024 = 3'h5,
      CLK_EXT_FALL = 3'h6,
      CLK_EXT_RISE = 3'h7
   } clock_sel_t;

endpackage

/* hw/capture_filter.sv */
/*
 Capture event detector: synchronises the capture pin and comparator input,
 optionally filters, and pulses on the selected edge.
 Assumes both inputs are asynchronous to sys_clk.
*/
`timescale 1ns/100ps
`default_nettype none
`include "wide_timer_params.svh"

module capture_filter #(
   parameter int FILTER_LEN = `WT_FILTER_LEN
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic capturePin,
   input wire logic comparatorIn,
   input wire logic useComparator,
   input wire logic filterOn,
   input wire logic risingEdge,
   output logic capEvent
);

   logic [1:0] pinSync_r;
   logic [1:0] cmpSync_r;
   logic [FILTER_LEN-1:0] history_r;
   logic level_r;
   logic prevLevel_r;
   logic sample;
   logic levelNxt;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pinSync_r <= 2'h0;
         cmpSync_r <= 2'h0;
      end else begin
         pinSync_r <= {pinSync_r[0], capturePin};
         cmpSync_r <= {cmpSync_r[0], comparatorIn};
      end
   end

   assign sample = useComparator ? cmpSync_r[1] : pinSync_r[1];

   // Level only moves after FILTER_LEN equal samples, so short spikes are lost
   always_comb begin
      levelNxt = level_r;
      if (!filterOn)
         levelNxt = sample;
      else if (&history_r)
         levelNxt = 1'b1;
      else if (~|history_r)
         levelNxt = 1'b0;
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         history_r <= '0;
         level_r <= 1'b0;
         prevLevel_r <= 1'b0;
         capEvent <= 1'b0;
      end else begin
         history_r <= {history_r[FILTER_LEN-2:0], sample};
         level_r <= levelNxt;
         prevLevel_r <= level_r;
         capEvent <= risingEdge ? (level_r & ~prevLevel_r) : (~level_r & prevLevel_r);
      end
   end

endmodule // capture_filter

`default_nettype wire

/* hw/wide_timer_byte_access.sv */
/*
 Wide timer/counter with two compare channels and a capture channel, reached
 from an 8-bit CPU bus; wide writes and counter and capture reads use one shared high-byte holding register.
 Assumes a CPU on the same clock issuing one-cycle read/write strobes.
*/
`timescale 1ns/100ps
`default_nettype none
`include "wide_timer_params.svh"

module wide_timer_byte_access #(
   parameter int PRESCALE_BITS = `WT_PRESCALE_BITS,
   parameter int FILTER_LEN = `WT_FILTER_LEN
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [3:0] busAddr,
   input wire logic [7:0] busWrData,
   input wire logic busWr,
   input wire logic busRd,
   output logic [7:0] busRdData,
   input wire logic timerPowerOff,
   input wire logic externalCountPin,
   input wire logic captureInputPin,
   input wire logic comparatorIn,
   output logic waveOutA,
   output logic waveOutB,
   output logic [3:0] timerIrq
);

   logic [7:0] timerControlA_r;
   logic [7:0] timerControlB_r;
   logic [3:0] timerFlag_r;
   logic [3:0] timerMask_r;
   logic [7:0] holdHigh_r;
   wide_timer_pkg::wide_t countValue_r;
   wide_timer_pkg::wide_t captureValue_r;
   wide_timer_pkg::wide_t cmpBuf_r [2];
   wide_timer_pkg::wide_t cmpActive_r [2];
   logic [1:0] wave_r;
   logic [PRESCALE_BITS-1:0] prescale_r;
   logic [2:0] extSync_r;
   logic blockMatch_r;
   logic enabled;
   logic wr;
   logic rd;
   logic timerTick;
   logic isPwm;
   logic atTop;
   logic overflow;
   logic capEvent;
   logic capIsTop;
   logic [1:0] match;
   logic [3:0] flagSet;
   logic [3:0] flagClr;
   wide_timer_pkg::wave_mode_t mode;
   wide_timer_pkg::clock_sel_t clockSel;
   wide_timer_pkg::wide_t topValue;

   assign enabled = !timerPowerOff;
   assign wr = busWr && enabled;
   assign rd = busRd && enabled;
   assign mode = wide_timer_pkg::wave_mode_t'({timerControlB_r[4:3], timerControlA_r[1:0]});
   assign clockSel = wide_timer_pkg::clock_sel_t'(timerControlB_r[2:0]);

   always_comb begin
      isPwm = 1'b0;
      capIsTop = 1'b0;
      topValue = `WT_MAX;
      unique case (mode)
         wide_timer_pkg::MODE_CTC_CMPA: topValue = cmpBuf_r[0];
         wide_timer_pkg::MODE_PWM_8BIT: begin
            isPwm = 1'b1;
            topValue = `WT_TOP_8BIT;
         end
         wide_timer_pkg::MODE_PWM_9BIT: begin
            isPwm = 1'b1;
            topValue = `WT_TOP_9BIT;
         end
         wide_timer_pkg::MODE_PWM_10BIT: begin
            isPwm = 1'b1;
            topValue = `WT_TOP_10BIT;
         end
         wide_timer_pkg::MODE_CTC_CAP: begin
            capIsTop = 1'b1;
            topValue = captureValue_r;
         end
         wide_timer_pkg::MODE_PWM_CAP: begin
            isPwm = 1'b1;
            capIsTop = 1'b1;
            topValue = captureValue_r;
         end
         wide_timer_pkg::MODE_PWM_CMPA: begin
            isPwm = 1'b1;
            topValue = cmpActive_r[0];
         end
         default: topValue = `WT_MAX;
      endcase
   end

   // Prescaler runs free so a source change does not restart its phase
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst)
         prescale_r <= '0;
      else if (enabled)
         prescale_r <= prescale_r + 1'b1;
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst)
         extSync_r <= 3'h0;
      else
         extSync_r <= {extSync_r[1:0], externalCountPin};
   end

   always_comb begin
      unique case (clockSel)
         wide_timer_pkg::CLK_STOP: timerTick = 1'b0;
         wide_timer_pkg::CLK_DIV1: timerTick = 1'b1;
         wide_timer_pkg::CLK_DIV8: timerTick = &prescale_r[2:0];
         wide_timer_pkg::CLK_DIV64: timerTick = &prescale_r[5:0];
         wide_timer_pkg::CLK_DIV256: timerTick = &prescale_r[7:0];
         wide_timer_pkg::CLK_DIV1024: timerTick = &prescale_r[9:0];
         wide_timer_pkg::CLK_EXT_FALL: timerTick = extSync_r[2] & ~extSync_r[1];
         wide_timer_pkg::CLK_EXT_RISE: timerTick = ~extSync_r[2] & extSync_r[1];
      endcase
      timerTick = timerTick && enabled;
   end

   assign atTop = (countValue_r == topValue);
   assign overflow = timerTick && (isPwm ? atTop : (countValue_r == `WT_MAX));

   // Shared holding register: high-byte writes fill it, counter and capture low-byte reads fill it
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst)
         holdHigh_r <= `WT_RESET_BYTE;
      else if (wr && (busAddr == `WT_ADDR_CNT_H || busAddr == `WT_ADDR_CMPA_H ||
                      busAddr == `WT_ADDR_CMPB_H || busAddr == `WT_ADDR_CAP_H))
         holdHigh_r <= busWrData;
      else if (rd && busAddr == `WT_ADDR_CNT_L)
         holdHigh_r <= countValue_r[15:8];
      else if (rd && busAddr == `WT_ADDR_CAP_L)
         holdHigh_r <= captureValue_r[15:8];
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst)
         countValue_r <= `WT_BOTTOM;
      else if (wr && busAddr == `WT_ADDR_CNT_L)
         countValue_r <= {holdHigh_r, busWrData};
      else if (timerTick)
         countValue_r <= atTop ? `WT_BOTTOM : countValue_r + 1'b1;
   end

   // A counter write suppresses the match on the next timer tick
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst)
         blockMatch_r <= 1'b0;
      else if (wr && busAddr == `WT_ADDR_CNT_L)
         blockMatch_r <= 1'b1;
      else if (timerTick)
         blockMatch_r <= 1'b0;
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst)
         captureValue_r <= `WT_RESET_WIDE;
      else if (capEvent && enabled)
         captureValue_r <= countValue_r;
      else if (wr && capIsTop && busAddr == `WT_ADDR_CAP_L)
         captureValue_r <= {holdHigh_r, busWrData};
   end

   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++) begin : g_cmp
         localparam logic [3:0] ADDR_L = ch ? `WT_ADDR_CMPB_L : `WT_ADDR_CMPA_L;
         localparam int COM_LO = ch ? 4 : 6;
         logic [1:0] com;
         assign com = timerControlA_r[COM_LO+1:COM_LO];
         assign match[ch] = timerTick && !blockMatch_r && countValue_r == cmpActive_r[ch];

         always_ff @(posedge sys_clk or posedge rst) begin
            if (rst)
               cmpBuf_r[ch] <= `WT_RESET_WIDE;
            else if (wr && busAddr == ADDR_L)
               cmpBuf_r[ch] <= {holdHigh_r, busWrData};
         end

         // PWM modes take the new value only at top, so a period is never torn
         always_ff @(posedge sys_clk or posedge rst) begin
            if (rst)
               cmpActive_r[ch] <= `WT_RESET_WIDE;
            else if (!isPwm || (timerTick && atTop))
               cmpActive_r[ch] <= cmpBuf_r[ch];
         end

         always_ff @(posedge sys_clk or posedge rst) begin
            if (rst)
               wave_r[ch] <= 1'b0;
            else if (ch == 0 && mode == wide_timer_pkg::MODE_PWM_CMPA)
               wave_r[ch] <= wave_r[ch];
            else if (isPwm && com[1]) begin
               if (match[ch])
                  wave_r[ch] <= ~com[0];
               else if (timerTick && atTop)
                  wave_r[ch] <= com[0];
            end else if (!isPwm && match[ch]) begin
               unique case (com)
                  2'h0: wave_r[ch] <= wave_r[ch];
                  2'h1: wave_r[ch] <= ~wave_r[ch];
                  2'h2: wave_r[ch] <= 1'b0;
                  2'h3: wave_r[ch] <= 1'b1;
               endcase
            end
         end
      end
   endgenerate

   assign waveOutA = wave_r[0];
   assign waveOutB = wave_r[1];

   capture_filter #(
      .FILTER_LEN(FILTER_LEN)
   ) u_capture_filter (
      .sys_clk(sys_clk),
      .rst(rst),
      .capturePin(captureInputPin),
      .comparatorIn(comparatorIn),
      .useComparator(timerControlB_r[`WT_CTRLB_SRC]),
      .filterOn(timerControlB_r[`WT_CTRLB_FILT]),
      .risingEdge(timerControlB_r[`WT_CTRLB_EDGE]),
      .capEvent(capEvent)
   );

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         timerControlA_r <= `WT_RESET_BYTE;
         timerControlB_r <= `WT_RESET_BYTE;
         timerMask_r <= 4'h0;
      end else if (wr) begin
         if (busAddr == `WT_ADDR_CTRL_A)
            timerControlA_r <= busWrData;
         if (busAddr == `WT_ADDR_CTRL_B)
            timerControlB_r <= busWrData;
         if (busAddr == `WT_ADDR_MASK)
            timerMask_r <= busWrData[3:0];
      end
   end

   assign flagSet = {capEvent && enabled, match[1], match[0], overflow};
   assign flagClr = (wr && busAddr == `WT_ADDR_FLAG) ? busWrData[3:0] : 4'h0;

   // Hardware set wins over a write-one clear in the same cycle
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         timerFlag_r <= 4'h0;
         timerIrq <= 4'h0;
      end else begin
         timerFlag_r <= (timerFlag_r & ~flagClr) | flagSet;
         timerIrq <= timerFlag_r & timerMask_r;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst)
         busRdData <= 8'h00;
      else if (rd) begin
         unique case (busAddr)
            `WT_ADDR_CNT_L: busRdData <= countValue_r[7:0];
            `WT_ADDR_CNT_H: busRdData <= holdHigh_r;
            `WT_ADDR_CMPA_L: busRdData <= cmpBuf_r[0][7:0];
            `WT_ADDR_CMPA_H: busRdData <= cmpBuf_r[0][15:8];
            `WT_ADDR_CMPB_L: busRdData <= cmpBuf_r[1][7:0];
            `WT_ADDR_CMPB_H: busRdData <= cmpBuf_r[1][15:8];
            `WT_ADDR_CAP_L: busRdData <= captureValue_r[7:0];
            `WT_ADDR_CAP_H: busRdData <= holdHigh_r;
            `WT_ADDR_CTRL_A: busRdData <= timerControlA_r;
            `WT_ADDR_CTRL_B: busRdData <= timerControlB_r;
            `WT_ADDR_FLAG: busRdData <= {4'h0, timerFlag_r};
            `WT_ADDR_MASK: busRdData <= {4'h0, timerMask_r};
            default: busRdData <= 8'h00;
         endcase
      end
   end

   a_low_write_load: assert property (@(posedge sys_clk) disable iff (rst)
      (wr && busAddr == `WT_ADDR_CNT_L) |=>
      countValue_r == {$past(holdHigh_r), $past(busWrData)})
      else $error("counter low write did not load both bytes");
   a_low_read_copy: assert property (@(posedge sys_clk) disable iff (rst)
      (rd && !busWr && busAddr == `WT_ADDR_CAP_L) |=>
      holdHigh_r == $past(captureValue_r[15:8]))
      else $error("capture low read did not fill holding byte");
   a_cmp_read_direct: assert property (@(posedge sys_clk) disable iff (rst)
      (rd && !busWr && busAddr == `WT_ADDR_CMPA_H) |=>
      busRdData == $past(cmpBuf_r[0][15:8]) && $stable(holdHigh_r))
      else $error("compare high read used holding byte");
   a_hold_keeps: assert property (@(posedge sys_clk) disable iff (rst)
      (!busWr && !busRd) |=> $stable(holdHigh_r))
      else $error("holding byte changed without access");
   a_stop_idle: assert property (@(posedge sys_clk) disable iff (rst)
      (clockSel == wide_timer_pkg::CLK_STOP && !busWr) |=> $stable(countValue_r))
      else $error("counter moved with no clock source");
   a_power_idle: assert property (@(posedge sys_clk) disable iff (rst)
      timerPowerOff [*2] |-> $stable(countValue_r) && $stable(timerFlag_r))
      else $error("timer active while powered off");
   a_top_wrap: assert property (@(posedge sys_clk) disable iff (rst)
      (timerTick && atTop && !(busWr && busAddr == `WT_ADDR_CNT_L)) |=>
      countValue_r == `WT_BOTTOM)
      else $error("counter did not wrap at top");
   a_match_flag: assert property (@(posedge sys_clk) disable iff (rst)
      match[1] |=> timerFlag_r[`WT_FLAG_CMPB] ##1 timerIrq[`WT_FLAG_CMPB] == $past(timerMask_r[2]))
      else $error("match B flag or request missing");
   a_capture_copy: assert property (@(posedge sys_clk) disable iff (rst)
      (capEvent && enabled) |=>
      captureValue_r == $past(countValue_r) && timerFlag_r[`WT_FLAG_CAP])
      else $error("capture did not copy counter");
   a_pwm_a_quiet: assert property (@(posedge sys_clk) disable iff (rst)
      (mode == wide_timer_pkg::MODE_PWM_CMPA) |=> $stable(waveOutA))
      else $error("compare A output moved while it sets top");
   a_ctrl_write: assert property (@(posedge sys_clk) disable iff (rst)
      (wr && busAddr == `WT_ADDR_CTRL_A) |=> timerControlA_r == $past(busWrData))
      else $error("control A write not taken");

endmodule // wide_timer_byte_access

`default_nettype wire

/* testbench/cpu_bus_model.sv */
/*
 CPU side of the timer's 8-bit byte bus: single-byte transfers and wide writes.
 Assumes the timer takes strobes on the rising edge of sys_clk.
*/
`timescale 1ns/100ps
`default_nettype none

module cpu_bus_model (
   input wire logic sys_clk,
   output logic [3:0] busAddr,
   output logic [7:0] busWrData,
   output logic busWr,
   output logic busRd
);
   initial begin
      busAddr = 4'hf;
      busWrData = 8'h00;
      busWr = 1'b0;
      busRd = 1'b0;
   end

   // Idle lines carry inverted values so stale data never looks valid
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      busAddr <= a;
      busWrData <= d;
      busWr <= 1'b1;
      @(posedge sys_clk);
      busWr <= 1'b0;
      busAddr <= ~a;
      busWrData <= ~d;
   endtask

   task automatic rd(input logic [3:0] a);
      @(posedge sys_clk);
      busAddr <= a;
      busRd <= 1'b1;
      @(posedge sys_clk);
      busRd <= 1'b0;
      busAddr <= ~a;
   endtask

   // High byte first, low byte commits; no other access interleaves
   task automatic wr16(input logic [3:0] lowAddr, input logic [15:0] v);
      wr(lowAddr + 4'h1, v[15:8]);
      wr(lowAddr, v[7:0]);
   endtask
endmodule // cpu_bus_model

`default_nettype wire

/* testbench/testbench.sv */
/*
 Self-checking bench for the byte-accessed wide timer.
 Assumes the CPU model drives the bus; read results are queued and compared.
*/
`timescale 1ns/100ps
`default_nettype none
`include "wide_timer_params.svh"

module testbench;
   logic sys_clk;
   logic rst;
   logic timerPowerOff;
   logic externalCountPin;
   logic captureInputPin;
   logic comparatorIn;
   logic [3:0] busAddr;
   logic [7:0] busWrData;
   logic busWr;
   logic busRd;
   logic [7:0] busRdData;
   logic [3:0] timerIrq;
   logic waveOutA;
   logic waveOutB;
   logic rdLast = 1'b0;
   logic [7:0] expQ[$];
   logic [31:0] rnd = 32'h1f93;
   logic [3:0] a;
   int failures = 0;
   int n_checks = 0;

   cpu_bus_model cpu (.sys_clk(sys_clk), .busAddr(busAddr), .busWrData(busWrData),
      .busWr(busWr), .busRd(busRd));

   wide_timer_byte_access uut (.sys_clk(sys_clk), .rst(rst), .busAddr(busAddr),
      .busWrData(busWrData), .busWr(busWr), .busRd(busRd), .busRdData(busRdData),
      .timerPowerOff(timerPowerOff), .externalCountPin(externalCountPin),
      .captureInputPin(captureInputPin), .comparatorIn(comparatorIn),
      .waveOutA(waveOutA), .waveOutB(waveOutB), .timerIrq(timerIrq));

   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic close_out();
      if (failures == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic check_byte(input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected %0t read %h, wanted %h", $time, got, exp);
      end
   endtask

   task automatic check_irq(input logic [3:0] exp);
      n_checks++;
      if (timerIrq !== exp) begin
         failures++;
         $display("unexpected %0t irq %h, wanted %h", $time, timerIrq, exp);
      end
   endtask

   task automatic check_wave(input logic [1:0] exp);
      n_checks++;
      if ({waveOutB, waveOutA} !== exp) begin
         failures++;
         $display("unexpected %0t waves %b, wanted %b", $time, {waveOutB, waveOutA}, exp);
      end
   endtask

   task automatic rdx(input logic [3:0] ad, input logic [7:0] v);
      expQ.push_back(v);
      cpu.rd(ad);
   endtask

   task automatic rd16(input logic [3:0] ad, input logic [15:0] v);
      rdx(ad, v[7:0]);
      rdx(ad + 4'h1, v[15:8]);
   endtask

   // Read data is registered: look one edge after the strobe was taken
   always @(posedge sys_clk) begin
      if (rdLast) begin
         if (expQ.size() == 0) begin
            failures++;
            $display("unexpected %0t read result with no note", $time);
         end else begin
            check_byte(expQ.pop_front(), busRdData);
         end
      end
      rdLast <= busRd && !timerPowerOff;
   end

   initial begin
      repeat (20000) @(posedge sys_clk);
      failures++;
      close_out();
   end

   initial begin
      rst = 1'b1;
      timerPowerOff = 1'b0;
      externalCountPin = 1'b0;
      captureInputPin = 1'b0;
      comparatorIn = 1'b0;
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      rd16(`WT_ADDR_CNT_L, `WT_BOTTOM);
      rdx(`WT_ADDR_CTRL_A, 8'h00);
      rdx(`WT_ADDR_CTRL_B, 8'h00);
      rdx(`WT_ADDR_FLAG, 8'h00);
      cpu.wr16(`WT_ADDR_CNT_L, 16'h01ff);
      repeat (30) @(posedge sys_clk);
      rd16(`WT_ADDR_CNT_L, 16'h01ff);
      cpu.wr(`WT_ADDR_CMPA_H, 8'h5a);
      cpu.wr(`WT_ADDR_CMPA_L, 8'h11);
      cpu.wr(`WT_ADDR_CMPB_L, 8'h22);
      rdx(`WT_ADDR_CNT_L, 8'hff);
      rd16(`WT_ADDR_CMPA_L, 16'h5a11);
      rd16(`WT_ADDR_CMPB_L, 16'h5a22);
      rdx(`WT_ADDR_CNT_H, 8'h01);
      cpu.wr(4'hd, 8'hff);
      rdx(4'hc, 8'h00);
      for (int i = 0; i < 9; i++) begin
         rnd = lfsr(rnd);
         a = (i % 3 == 0) ? `WT_ADDR_CNT_L : (i % 3 == 1) ? `WT_ADDR_CMPA_L : `WT_ADDR_CMPB_L;
         cpu.wr16(a, rnd[15:0]);
         rd16(a, rnd[15:0]);
      end
      rnd = lfsr(rnd);
      cpu.wr(`WT_ADDR_CTRL_A, rnd[7:0]);
      cpu.wr(`WT_ADDR_CTRL_B, rnd[15:8] & 8'he0);
      rdx(`WT_ADDR_CTRL_A, rnd[7:0]);
      rdx(`WT_ADDR_CTRL_B, rnd[15:8] & 8'he0);
      cpu.wr(`WT_ADDR_CTRL_A, 8'h00);
      cpu.wr(`WT_ADDR_CTRL_B, 8'h00);
      // Count across MAX with both compare values just past the wrap
      // Channel A sets on match, channel B toggles on match
      cpu.wr(`WT_ADDR_CTRL_A, 8'hd0);
      cpu.wr(`WT_ADDR_MASK, 8'h05);
      cpu.wr16(`WT_ADDR_CMPA_L, 16'h0002);
      cpu.wr16(`WT_ADDR_CMPB_L, 16'h0003);
      cpu.wr16(`WT_ADDR_CNT_L, 16'hfffe);
      cpu.wr(`WT_ADDR_CTRL_B, 8'(wide_timer_pkg::CLK_DIV1));
      repeat (20) @(posedge sys_clk);
      cpu.wr(`WT_ADDR_CTRL_B, 8'h00);
      repeat (4) @(posedge sys_clk);
      rdx(`WT_ADDR_FLAG, 8'h07);
      check_irq(4'h5);
      check_wave(2'b11);
      cpu.wr(`WT_ADDR_FLAG, 8'h05);
      rdx(`WT_ADDR_FLAG, 8'h02);
      check_irq(4'h0);
      // Fixed 8-bit top: overflow must come long before MAX
      cpu.wr(`WT_ADDR_FLAG, 8'h0f);
      cpu.wr16(`WT_ADDR_CMPA_L, 16'h0200);
      cpu.wr16(`WT_ADDR_CMPB_L, 16'h0200);
      cpu.wr16(`WT_ADDR_CNT_L, 16'h00f0);
      cpu.wr(`WT_ADDR_CTRL_A, 8'h01);
      cpu.wr(`WT_ADDR_CTRL_B, 8'h09);
      repeat (40) @(posedge sys_clk);
      cpu.wr(`WT_ADDR_CTRL_B, 8'h00);
      cpu.wr(`WT_ADDR_CTRL_A, 8'h00);
      rdx(`WT_ADDR_FLAG, 8'h01);
      cpu.wr(`WT_ADDR_FLAG, 8'h0f);
      cpu.wr16(`WT_ADDR_CNT_L, 16'h0000);
      cpu.wr(`WT_ADDR_CTRL_B, 8'(wide_timer_pkg::CLK_EXT_RISE));
      repeat (3) begin
         repeat (6) @(posedge sys_clk);
         externalCountPin <= 1'b1;
         repeat (6) @(posedge sys_clk);
         externalCountPin <= 1'b0;
      end
      repeat (6) @(posedge sys_clk);
      cpu.wr(`WT_ADDR_CTRL_B, 8'h00);
      rd16(`WT_ADDR_CNT_L, 16'h0003);
      // Capture from the pin, unfiltered, rising edge
      cpu.wr16(`WT_ADDR_CNT_L, 16'h1234);
      cpu.wr(`WT_ADDR_CTRL_B, 8'h40);
      captureInputPin <= 1'b1;
      repeat (10) @(posedge sys_clk);
      rd16(`WT_ADDR_CAP_L, 16'h1234);
      rdx(`WT_ADDR_FLAG, 8'h08);
      // A two-cycle spike must not get through the filter
      captureInputPin <= 1'b0;
      cpu.wr(`WT_ADDR_FLAG, 8'h08);
      cpu.wr(`WT_ADDR_CTRL_B, 8'hc0);
      cpu.wr16(`WT_ADDR_CNT_L, 16'h4321);
      captureInputPin <= 1'b1;
      repeat (2) @(posedge sys_clk);
      captureInputPin <= 1'b0;
      repeat (14) @(posedge sys_clk);
      rdx(`WT_ADDR_FLAG, 8'h00);
      cpu.wr(`WT_ADDR_CTRL_B, 8'he0);
      comparatorIn <= 1'b1;
      repeat (16) @(posedge sys_clk);
      rd16(`WT_ADDR_CAP_L, 16'h4321);
      // Powered off: bus writes and reads are dropped
      timerPowerOff <= 1'b1;
      cpu.wr16(`WT_ADDR_CNT_L, 16'hffff);
      cpu.rd(`WT_ADDR_CNT_L);
      timerPowerOff <= 1'b0;
      rd16(`WT_ADDR_CNT_L, 16'h4321);
      repeat (4) @(posedge sys_clk);
      close_out();
   end
endmodule // testbench

`default_nettype wire
